// [include/hawt_pkg.sv]
// package: register map, field layout and timing of the halt wake-up timer
package hawt_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CSR_OFS = 8'h2b;
  localparam logic [7:0] PR_OFS = 8'h2c;
  localparam logic [7:0] MASK_OFS = 8'h2d;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int EN_BIT = 0;
  localparam int MEAS_BIT = 1;
  localparam int FLAG_BIT = 2;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] PR_RST = 8'hff;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] PR_FORBIDDEN = 8'h00;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int PRE_MULT = 64;
  localparam int CNT_W = 14;
  localparam int CLK_PERIOD_NS = 100;
  localparam int RC_STARTUP_NS = 10000;
  localparam int RC_STARTUP_CYC =
    (RC_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SU_W = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_START = 4'b0010,
    ST_COUNT = 4'b0100,
    ST_WAKE = 4'b1000
  } hawt_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } hawt_bus_req_t;

endpackage

// [rtl/hawt_rc_sync.sv]
// module: three-flop synchroniser with edge pulse for the rc oscillator
module hawt_rc_sync (
  input wire logic ref_clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic async_in, // level from outside the clock domain
  output logic level_ff, // filtered level
  output logic rise_ff // one-cycle pulse on a rising change
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // ****************************************************************
  // synchroniser chain
  // ****************************************************************
  // s1 feeds only s2, so metastability never reaches a decision
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // a change counts once the second and third stages agree
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
    end else begin
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !level_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

endmodule

// [rtl/hawt_timer.sv]
// module: auto wake-up timer that ends halt mode after a programmed delay
//
// Added by the designer: strobed register access.
module hawt_timer
  import hawt_pkg::*;
#(
  parameter int STARTUP_CYC = RC_STARTUP_CYC // cycles of rc start-up
) (
  input wire logic ref_clk, // 10 MHz system clock
  input wire logic nrst, // async reset, active low
  input wire hawt_pkg::hawt_bus_req_t bus_req, // register request
  output logic [7:0] rdata_ff, // read data, cycle after read
  input wire logic halt_active, // core is in halt mode
  input wire logic rc_osc_in, // wake-up rc oscillator output
  output logic rc_osc_en_ff, // runs the rc oscillator
  output logic capture_in1_ff, // timer_capture_input_1 feed
  output logic wakeup_ff, // one-cycle wake-up request
  output logic irq_ff // level interrupt
);
  import hawt_pkg::*;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (STARTUP_CYC < 1 || STARTUP_CYC >= (1 << SU_W)) begin : g_su_chk
    $error("start-up count out of range");
  end
  if ((PRE_MULT * 255) >= (1 << CNT_W)) begin : g_cnt_chk
    $error("tick counter too narrow");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  // terminal tick count: 64 rc periods per prescaler step
  function automatic logic [CNT_W-1:0] hawt_term(input logic [7:0] pr);
    hawt_term = CNT_W'(PRE_MULT) * CNT_W'(pr);
  endfunction

  function automatic logic hit(input logic [7:0] ofs);
    hit = (bus_req.addr == ofs);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  hawt_state_t state_ff;
  hawt_state_t nxt_state;
  logic en_ff;
  logic meas_ff;
  logic flag_ff;
  logic [7:0] pr_ff;
  logic [7:0] mask_ff;
  logic [CNT_W-1:0] tick_cnt_ff;
  logic [SU_W-1:0] su_cnt_ff;
  logic halt_d_ff;
  logic rc_level;
  logic rc_rise;
  logic halt_entry;
  logic fire;
  logic csr_rd;
  logic [7:0] csr_view;

  hawt_rc_sync u_rc_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .async_in(rc_osc_in),
    .level_ff(rc_level),
    .rise_ff(rc_rise)
  );

  assign halt_entry = halt_active && !halt_d_ff;
  assign csr_rd = bus_req.rd && hit(CSR_OFS);
  assign fire = (state_ff == ST_COUNT) && rc_rise &&
    (tick_cnt_ff == hawt_term(pr_ff) - CNT_W'(1));

  always_comb begin
    csr_view = 8'h00;
    csr_view[FLAG_BIT] = flag_ff;
    csr_view[MEAS_BIT] = meas_ff;
    csr_view[EN_BIT] = en_ff;
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  // only software moves the enable and measure bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      en_ff <= CSR_RST[EN_BIT];
      meas_ff <= CSR_RST[MEAS_BIT];
    end else if (bus_req.wr && hit(CSR_OFS)) begin
      en_ff <= bus_req.wdata[EN_BIT];
      meas_ff <= bus_req.wdata[MEAS_BIT];
    end
  end

  // a zero prescaler is ignored so the delay is never degenerate
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pr_ff <= PR_RST;
    end else if (bus_req.wr && hit(PR_OFS) &&
                 bus_req.wdata != PR_FORBIDDEN) begin
      pr_ff <= bus_req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      mask_ff <= MASK_RST;
    end else if (bus_req.wr && hit(MASK_OFS)) begin
      mask_ff <= bus_req.wdata;
    end
  end

  // ****************************************************************
  // wake-up flag
  // ****************************************************************
  // a terminal count landing on the clearing read still sets the flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_ff <= CSR_RST[FLAG_BIT];
    end else if (fire) begin
      flag_ff <= 1'b1;
    end else if (csr_rd) begin
      flag_ff <= 1'b0;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= 8'h00;
    end else if (bus_req.rd) begin
      if (hit(CSR_OFS)) begin
        rdata_ff <= csr_view;
      end else if (hit(PR_OFS)) begin
        rdata_ff <= pr_ff;
      end else if (hit(MASK_OFS)) begin
        rdata_ff <= mask_ff & 8'h04;
      end else begin
        rdata_ff <= 8'h00;
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      halt_d_ff <= 1'b0;
    end else begin
      halt_d_ff <= halt_active;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (halt_entry && en_ff) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (!halt_active || !en_ff) begin
          nxt_state = ST_IDLE;
        end else if (su_cnt_ff == '0) begin
          nxt_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!halt_active || !en_ff) begin
          nxt_state = ST_IDLE;
        end else if (fire) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (!halt_active) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // start-up wait covers the oscillator settling time
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      su_cnt_ff <= '0;
    end else if (state_ff == ST_IDLE) begin
      su_cnt_ff <= SU_W'(STARTUP_CYC - 1);
    end else if (state_ff == ST_START && su_cnt_ff != '0) begin
      su_cnt_ff <= su_cnt_ff - SU_W'(1);
    end
  end

  // counts rising edges of the synchronised rc clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_ff <= '0;
    end else if (state_ff != ST_COUNT) begin
      tick_cnt_ff <= '0;
    end else if (rc_rise) begin
      tick_cnt_ff <= tick_cnt_ff + CNT_W'(1);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wakeup_ff <= 1'b0;
    end else begin
      wakeup_ff <= fire;
    end
  end

  // oscillator runs for measurement or while timing a halt
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rc_osc_en_ff <= 1'b0;
      capture_in1_ff <= 1'b0;
    end else begin
      rc_osc_en_ff <= meas_ff || (nxt_state == ST_START) ||
        (nxt_state == ST_COUNT);
      capture_in1_ff <= meas_ff && rc_level;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= flag_ff && mask_ff[FLAG_BIT];
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  flag_set_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    fire |=> flag_ff && wakeup_ff)
    else $error("flag or wake-up missing after terminal count");

  flag_clear_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    csr_rd && !fire |=> !flag_ff)
    else $error("flag not cleared by status read");

  meas_route_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    meas_ff |=> rc_osc_en_ff && (capture_in1_ff == $past(rc_level)))
    else $error("measurement routing wrong");

  meas_off_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !meas_ff |=> !capture_in1_ff)
    else $error("capture driven while measurement off");

  wake_enable_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $rose(state_ff == ST_START) |-> $past(en_ff) && $past(halt_entry))
    else $error("timing started without enable and halt entry");

  pr_store_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    bus_req.wr && hit(PR_OFS) && bus_req.wdata != 8'h00
    |=> pr_ff == $past(bus_req.wdata))
    else $error("prescaler write not stored");

  pr_zero_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    bus_req.wr && hit(PR_OFS) && bus_req.wdata == 8'h00
    |=> $stable(pr_ff))
    else $error("zero prescaler accepted");

  term_count_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wakeup_ff |-> $past(tick_cnt_ff) == hawt_term($past(pr_ff)) - 14'h1)
    else $error("wake-up at wrong tick count");

  csr_reserved_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    csr_rd |=> rdata_ff[7:3] == 5'h00 && rdata_ff[2] == $past(flag_ff))
    else $error("status read shows wrong bits");

  startup_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $rose(state_ff == ST_COUNT) |-> $past(su_cnt_ff) == '0)
    else $error("counting began before start-up wait");

  irq_level_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    irq_ff |-> $past(flag_ff) && $past(mask_ff[FLAG_BIT]))
    else $error("interrupt without unmasked flag");

  wake_pulse_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    wakeup_ff |=> !wakeup_ff)
    else $error("wake-up request longer than one cycle");

  flag_ro_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    bus_req.wr && hit(CSR_OFS) && !fire && !flag_ff |=> !flag_ff)
    else $error("software write set the wake-up flag");

  osc_timing_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == ST_COUNT |-> rc_osc_en_ff)
    else $error("oscillator off while timing halt");

  fire_c: cover property (@(posedge ref_clk) disable iff (!nrst) fire);
  meas_c: cover property (
    @(posedge ref_clk) disable iff (!nrst) meas_ff && rc_rise);
  abort_c: cover property (
    @(posedge ref_clk) disable iff (!nrst)
    state_ff == ST_COUNT && !halt_active);
  irq_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq_ff));
  pr_zero_c: cover property (@(posedge ref_clk) disable iff (!nrst)
    bus_req.wr && hit(PR_OFS) && bus_req.wdata == PR_FORBIDDEN);

endmodule

// [verif/hawt_timer_tb.sv]
// testbench: register, wake-up and measurement checks of the halt timer
module hawt_timer_tb import hawt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // ****************************************************************
  // signals and design
  // ****************************************************************
  logic ref_clk;
  logic nrst;
  hawt_bus_req_t req;
  logic [7:0] rdata_ff;
  logic halt_active;
  logic rc_osc_in;
  logic rc_osc_en_ff;
  logic capture_in1_ff;
  logic wakeup_ff;
  logic irq_ff;
  int n_errors = 0;
  int tests_run = 0;
  int n_wake = 0;

  // short start-up keeps the run brief; timing below assumes 2 cycles
  hawt_timer #(.STARTUP_CYC(2)) uut (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .bus_req(req),
    .rdata_ff(rdata_ff),
    .halt_active(halt_active),
    .rc_osc_in(rc_osc_in),
    .rc_osc_en_ff(rc_osc_en_ff),
    .capture_in1_ff(capture_in1_ff),
    .wakeup_ff(wakeup_ff),
    .irq_ff(irq_ff)
  );

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    if (wakeup_ff === 1'b1) n_wake <= n_wake + 1;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe: sample mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge ref_clk);
    req.rd <= 1'b0;
    @(negedge ref_clk);
    check(rdata_ff, exp);
  endtask

  // each rise is held 4 cycles so the 3-flop synchroniser sees it
  task automatic rc_rises(input int n);
    repeat (n) begin
      rc_osc_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rc_osc_in <= 1'b0;
      repeat (4) @(posedge ref_clk);
    end
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(CSR_OFS, 8'h00);
    rd(PR_OFS, 8'hff);
    rd(MASK_OFS, 8'h00);
    rd(8'h30, 8'h00);
    wr(CSR_OFS, 8'hfc);
    rd(CSR_OFS, 8'h00);
    wr(PR_OFS, 8'h00);
    rd(PR_OFS, 8'hff);
    wr(PR_OFS, 8'h01);
    rd(PR_OFS, 8'h01);
    wr(PR_OFS, 8'hfe);
    rd(PR_OFS, 8'hfe);
  endtask

  task automatic t_measure();
    wr(CSR_OFS, 8'h02);
    rc_osc_in <= 1'b1;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(rc_osc_en_ff), 8'h01);
    check(8'(capture_in1_ff), 8'h01);
    @(posedge ref_clk);
    rc_osc_in <= 1'b0;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(capture_in1_ff), 8'h00);
    @(posedge ref_clk);
    rc_osc_in <= 1'b1;
    wr(CSR_OFS, 8'h00);
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    check(8'(capture_in1_ff), 8'h00);
    check(8'(rc_osc_en_ff), 8'h00);
    rd(CSR_OFS, 8'h00);
    @(posedge ref_clk);
    rc_osc_in <= 1'b0;
  endtask

  task automatic t_wake(input logic [7:0] pr, input logic [7:0] msk);
    int w0;
    w0 = n_wake;
    wr(PR_OFS, pr);
    wr(MASK_OFS, msk);
    rd(MASK_OFS, {5'h00, msk[2], 2'h0});
    wr(CSR_OFS, 8'h01);
    @(posedge ref_clk);
    halt_active <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rc_rises(64 * pr - 1);
    check(8'(n_wake - w0), 8'h00);
    rc_rises(1);
    @(negedge ref_clk);
    check(8'(n_wake - w0), 8'h01);
    check(8'(irq_ff), {7'h00, msk[2]});
    @(posedge ref_clk);
    halt_active <= 1'b0;
    rd(CSR_OFS, 8'h05);
    repeat (2) @(negedge ref_clk);
    check(8'(irq_ff), 8'h00);
    rd(CSR_OFS, 8'h01);
  endtask

  // halt dropped mid-delay: the wake-up must never come
  task automatic t_abort();
    int w0;
    w0 = n_wake;
    wr(PR_OFS, 8'h01);
    @(posedge ref_clk);
    halt_active <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rc_rises(20);
    halt_active <= 1'b0;
    rc_rises(60);
    check(8'(n_wake - w0), 8'h00);
    rd(CSR_OFS, 8'h01);
    wr(CSR_OFS, 8'h00);
    @(posedge ref_clk);
    halt_active <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rc_rises(70);
    halt_active <= 1'b0;
    check(8'(n_wake - w0), 8'h00);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    nrst = 1'b0;
    req = '0;
    halt_active = 1'b0;
    rc_osc_in = 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_measure();
    t_wake(8'h02, 8'h04);
    t_wake(8'h01, 8'h00);
    t_abort();
    finish_test();
  end

  // the sequence needs about 2900 cycles; allow a wide margin
  initial begin
    repeat (8000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end

endmodule
